// >>> ext_branch_pkg.sv
/*
 * shared constants and carrier types for the extend and indirect branch
 * execute unit. assumes a 16-bit instruction stream, 16 x 32 registers.
 */
package ext_branch_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_AW = 4;
  localparam int unsigned INSN_W = 16;
  // opcode field positions
  localparam int unsigned TOP_HI = 15;
  localparam int unsigned TOP_LO = 12;
  localparam int unsigned RN_HI = 11;
  localparam int unsigned RN_LO = 8;
  localparam int unsigned RM_HI = 7;
  localparam int unsigned RM_LO = 4;
  localparam int unsigned LOW_HI = 3;
  localparam int unsigned LOW_LO = 0;
  localparam int unsigned SUB_HI = 7;
  localparam int unsigned BYTE_SIGN = 7;
  localparam int unsigned WORD_SIGN = 15;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned WORD_W = 16;
  // opcode codes
  localparam logic [3:0] TOP_EXT = 4'h6;
  localparam logic [3:0] TOP_SYS = 4'h4;
  localparam logic [3:0] LOW_SXB = 4'hE;
  localparam logic [3:0] LOW_SXW = 4'hF;
  localparam logic [3:0] LOW_ZXB = 4'hC;
  localparam logic [3:0] LOW_ZXW = 4'hD;
  localparam logic [7:0] SUB_JMP = 8'h2B;
  localparam logic [7:0] SUB_JSR = 8'h0B;
  // masks and return offset
  localparam logic [31:0] MASK_BYTE = 32'h000000FF;
  localparam logic [31:0] MASK_WORD = 32'h0000FFFF;
  localparam logic [31:0] RET_OFS = 32'h00000004;

  typedef enum logic [6:0] {
    OP_NONE = 7'h01,
    OP_SXB = 7'h02,
    OP_SXW = 7'h04,
    OP_ZXB = 7'h08,
    OP_ZXW = 7'h10,
    OP_JMP = 7'h20,
    OP_JSR = 7'h40
  } op_kind_t;

  // fetched instruction with its own address
  typedef struct packed {
    logic [15:0] insn;
    logic [31:0] addr;
  } fetch_word_t;

  // one register write-back
  typedef struct packed {
    logic valid;
    logic [3:0] idx;
    logic [31:0] data;
  } reg_write_t;

  // control transfer request
  typedef struct packed {
    logic valid;
    logic [31:0] target;
  } pc_load_t;
endpackage

// >>> ext_branch_exec.sv
/*
 * execute unit for sign/zero extension and the two delayed indirect
 * branches. assumes the fetch stage presents one instruction per cycle
 * with valid/ready, that register reads are combinational from the
 * register file, and that slot instructions other than those decoded here
 * are carried out by the rest of the core when slot_exec_out pulses.
 */
`timescale 1ns/1ps
`default_nettype none

// Operation
// RULE1 - byte sign extend opcode 0110 ... 1110
// RULE2 - word sign extend opcode 0110 ... 1111
// RULE3 - byte: bit 7 fills bits 8-31
// RULE4 - word: bit 15 fills bits 16-31
// RULE5 - byte zero extend opcode 0110 ... 1100
// RULE6 - word zero extend opcode 0110nnnnmmmm1101
// RULE7 - zero extend clears upper bits by mask
// RULE8 - jump opcode 0100mmmm00101011, two cycles
// RULE9 - jump target is full source register
// RULE10 - slot instruction runs before transfer
// RULE11 - interrupts, address errors held through slot
// RULE12 - branch in slot is illegal
// RULE13 - call opcode 0100mmmm00001011, saves return address
// RULE14 - return address is call address plus four
// RULE15 - call target is full source register
// RULE16 - branch effects precede slot effects
// RULE17 - target latched before slot runs
// RULE18 - extends one cycle; flag never touched
// RULE19 - illegal slot reported as event
module ext_branch_exec (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // instruction stream
  input wire logic insn_valid_in,
  input wire ext_branch_pkg::fetch_word_t fetch_in,
  output logic insn_ready_out,
  // register file read port
  output logic [3:0] src_idx_out,
  input wire logic [31:0] src_data_in,
  // results
  output ext_branch_pkg::reg_write_t gpr_write_out,
  output ext_branch_pkg::reg_write_t pr_write_out,
  output ext_branch_pkg::pc_load_t pc_load_out,
  output logic slot_exec_out,
  output logic except_hold_out,
  output logic illegal_slot_out,
  output logic flag_write_out
);

  // decoded op of the current word
  ext_branch_pkg::op_kind_t op_kind;
  logic [31:0] ext_result;
  logic accept;
  logic in_slot_r;
  logic [31:0] target_r;
  logic insn_ready_r;

  // is the word any branch; used to police the slot
  function automatic logic is_branch(input logic [15:0] w);
    is_branch = (w[ext_branch_pkg::TOP_HI:ext_branch_pkg::TOP_LO] ==
                 ext_branch_pkg::TOP_SYS) &&
                ((w[ext_branch_pkg::SUB_HI:0] == ext_branch_pkg::SUB_JMP) ||
                 (w[ext_branch_pkg::SUB_HI:0] == ext_branch_pkg::SUB_JSR));
  endfunction

  // opcode decode
  always_comb begin
    logic [15:0] w;
    w = fetch_in.insn;
    op_kind = ext_branch_pkg::OP_NONE;
    if (w[ext_branch_pkg::TOP_HI:ext_branch_pkg::TOP_LO] ==
        ext_branch_pkg::TOP_EXT) begin
      case (w[ext_branch_pkg::LOW_HI:ext_branch_pkg::LOW_LO])
        // RULE1 byte sign decode
        ext_branch_pkg::LOW_SXB: op_kind = ext_branch_pkg::OP_SXB;
        // RULE2 word sign decode
        ext_branch_pkg::LOW_SXW: op_kind = ext_branch_pkg::OP_SXW;
        // RULE5 byte zero decode
        ext_branch_pkg::LOW_ZXB: op_kind = ext_branch_pkg::OP_ZXB;
        // RULE6 word zero decode
        ext_branch_pkg::LOW_ZXW: op_kind = ext_branch_pkg::OP_ZXW;
        default: op_kind = ext_branch_pkg::OP_NONE;
      endcase
    end else if (w[ext_branch_pkg::TOP_HI:ext_branch_pkg::TOP_LO] ==
                 ext_branch_pkg::TOP_SYS) begin
      case (w[ext_branch_pkg::SUB_HI:0])
        // RULE8 jump decode
        ext_branch_pkg::SUB_JMP: op_kind = ext_branch_pkg::OP_JMP;
        // RULE13 call decode
        ext_branch_pkg::SUB_JSR: op_kind = ext_branch_pkg::OP_JSR;
        default: op_kind = ext_branch_pkg::OP_NONE;
      endcase
    end
  end

  // source register select; branches carry their source in bits 11:8
  always_comb begin
    if (fetch_in.insn[ext_branch_pkg::TOP_HI:ext_branch_pkg::TOP_LO] ==
        ext_branch_pkg::TOP_SYS) begin
      // RULE9 RULE15 branch source field
      src_idx_out =
        fetch_in.insn[ext_branch_pkg::RN_HI:ext_branch_pkg::RN_LO];
    end else begin
      src_idx_out =
        fetch_in.insn[ext_branch_pkg::RM_HI:ext_branch_pkg::RM_LO];
    end
  end

  // extension datapath
  always_comb begin
    case (op_kind)
      // RULE3 replicate bit 7
      ext_branch_pkg::OP_SXB: ext_result = {
        {(ext_branch_pkg::DATA_W - ext_branch_pkg::BYTE_W)
          {src_data_in[ext_branch_pkg::BYTE_SIGN]}},
        src_data_in[ext_branch_pkg::BYTE_W-1:0]};
      // RULE4 replicate bit 15
      ext_branch_pkg::OP_SXW: ext_result = {
        {(ext_branch_pkg::DATA_W - ext_branch_pkg::WORD_W)
          {src_data_in[ext_branch_pkg::WORD_SIGN]}},
        src_data_in[ext_branch_pkg::WORD_W-1:0]};
      // RULE7 byte mask
      ext_branch_pkg::OP_ZXB:
        ext_result = src_data_in & ext_branch_pkg::MASK_BYTE;
      // RULE7 word mask
      ext_branch_pkg::OP_ZXW:
        ext_result = src_data_in & ext_branch_pkg::MASK_WORD;
      default: ext_result = src_data_in;
    endcase
  end

  // one word taken per cycle while ready is high
  assign accept = insn_valid_in && insn_ready_r;

  // issue throttle: the cycle after a branch is its second cycle
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      insn_ready_r <= 1'b0;
    end else if (accept && !in_slot_r &&
                 (op_kind == ext_branch_pkg::OP_JMP ||
                  op_kind == ext_branch_pkg::OP_JSR)) begin
      // RULE8 second cycle, slot waits
      insn_ready_r <= 1'b0;
    end else begin
      insn_ready_r <= 1'b1;
    end
  end
  assign insn_ready_out = insn_ready_r;

  // slot tracking; stays armed until the slot word arrives
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      in_slot_r <= 1'b0;
    end else if (accept) begin
      // RULE10 next word is the slot
      in_slot_r <= !in_slot_r &&
                   (op_kind == ext_branch_pkg::OP_JMP ||
                    op_kind == ext_branch_pkg::OP_JSR);
    end
  end

  // branch target captured at decode
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      target_r <= 32'h00000000;
    end else if (accept && !in_slot_r &&
                 (op_kind == ext_branch_pkg::OP_JMP ||
                  op_kind == ext_branch_pkg::OP_JSR)) begin
      // RULE17 sample before slot writes
      // RULE9 RULE15 full 32-bit target
      target_r <= src_data_in;
    end
  end

  // general register write-back, one cycle after issue
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      gpr_write_out <= '0;
    end else begin
      // RULE18 extends finish in one cycle
      gpr_write_out.valid <= accept &&
        (op_kind == ext_branch_pkg::OP_SXB ||
         op_kind == ext_branch_pkg::OP_SXW ||
         op_kind == ext_branch_pkg::OP_ZXB ||
         op_kind == ext_branch_pkg::OP_ZXW);
      gpr_write_out.idx <=
        fetch_in.insn[ext_branch_pkg::RN_HI:ext_branch_pkg::RN_LO];
      gpr_write_out.data <= ext_result;
    end
  end

  // return register write; issued with the call, ahead of the slot
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pr_write_out <= '0;
    end else begin
      // RULE16 call effect before slot effect
      pr_write_out.valid <= accept && !in_slot_r &&
                            op_kind == ext_branch_pkg::OP_JSR;
      pr_write_out.idx <= '0;
      // RULE14 address plus four
      pr_write_out.data <= fetch_in.addr + ext_branch_pkg::RET_OFS;
    end
  end

  // control transfer and slot events
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pc_load_out <= '0;
      slot_exec_out <= 1'b0;
      illegal_slot_out <= 1'b0;
    end else begin
      // RULE10 transfer only after slot
      pc_load_out.valid <= accept && in_slot_r && !is_branch(fetch_in.insn);
      pc_load_out.target <= target_r;
      slot_exec_out <= accept && in_slot_r && !is_branch(fetch_in.insn);
      // RULE12 RULE19 branch in slot flagged
      illegal_slot_out <= accept && in_slot_r && is_branch(fetch_in.insn);
    end
  end

  // exception hold from the cycle after branch issue until the slot word is taken
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      except_hold_out <= 1'b0;
    end else begin
      // RULE11 defer interrupts, address errors
      except_hold_out <= (accept && !in_slot_r &&
                          (op_kind == ext_branch_pkg::OP_JMP ||
                           op_kind == ext_branch_pkg::OP_JSR)) ||
                         (in_slot_r && !accept);
    end
  end

  // condition flag is never written by these ops
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flag_write_out <= 1'b0;
    end else begin
      // RULE18 flag left alone
      flag_write_out <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// >>> ext_branch_checker.sv
/* port assertions for ext_branch_exec; assumes one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module ext_branch_checker (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // stream in
  input wire logic insn_valid_in,
  input wire ext_branch_pkg::fetch_word_t fetch_in,
  input wire logic [31:0] src_data_in,
  // outputs
  input wire logic insn_ready_out,
  input wire ext_branch_pkg::reg_write_t gpr_write_out,
  input wire ext_branch_pkg::reg_write_t pr_write_out,
  input wire ext_branch_pkg::pc_load_t pc_load_out,
  input wire logic slot_exec_out,
  input wire logic except_hold_out,
  input wire logic illegal_slot_out,
  input wire logic flag_write_out
);
  // decode of the offered word
  wire [15:0] ins = fetch_in.insn;
  wire take = insn_valid_in && insn_ready_out;
  wire ext = ins[15:12] == 4'h6 && ins[3:2] == 2'b11;
  wire br = ins[15:12] == 4'h4 && {ins[7:6], ins[4:0]} == 7'h0B;
  logic slot_r;
  wire first = take && !slot_r;
  // slot word is never decoded as a normal op
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) slot_r <= 1'b0;
    else if (take) slot_r <= br && !slot_r;
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  a_ext_write: assert property (first && ext |=>
    gpr_write_out.valid && gpr_write_out.idx == $past(ins[11:8]))
    else $error("extend write missing");
  a_sxb_fill: assert property (first && ext && ins[1:0] == 2'b10 |=>
    gpr_write_out.data == {{24{$past(src_data_in[7])}},
    $past(src_data_in[7:0])}) else $error("byte sign fill wrong");
  a_zxw_mask: assert property (first && ext && ins[1:0] == 2'b01 |=>
    gpr_write_out.data == ($past(src_data_in) & 32'h0000FFFF))
    else $error("word mask wrong");
  a_branch_gap: assert property (first && br |=>
    !insn_ready_out && except_hold_out) else $error("no branch gap");
  a_call_ret: assert property (first && br && !ins[5] |=>
    pr_write_out.valid && pr_write_out.data == $past(fetch_in.addr) + 4)
    else $error("return address wrong");
  a_load_slot: assert property (pc_load_out.valid |->
    slot_exec_out && $past(slot_r)) else $error("load without slot");
  a_illegal_only: assert property (illegal_slot_out |->
    !pc_load_out.valid && !slot_exec_out) else $error("illegal slot ran");
  a_flag_kept: assert property (flag_write_out == 1'b0)
    else $error("flag written");
  c_call: cover property (pr_write_out.valid);
  c_load: cover property (pc_load_out.valid);
  c_illegal: cover property (illegal_slot_out);
endmodule
bind ext_branch_exec ext_branch_checker chk (.sys_clk_in, .rstn_in,
  .insn_valid_in, .fetch_in, .src_data_in, .insn_ready_out, .gpr_write_out,
  .pr_write_out, .pc_load_out, .slot_exec_out, .except_hold_out,
  .illegal_slot_out, .flag_write_out);
`default_nettype wire

// >>> ext_branch_regs.sv
/* register file partner; assumes the bench preloads entries. */
`timescale 1ns/1ps
`default_nettype none
module ext_branch_regs (
  // clock and read port
  input wire logic sys_clk_in,
  input wire logic [3:0] rd_idx_in,
  output logic [31:0] rd_data_out,
  // write-back
  input wire ext_branch_pkg::reg_write_t wr_in
);
  logic [31:0] mem [16];
  // same-cycle read, no forwarding of a pending write
  assign rd_data_out = mem[rd_idx_in];
  always @(posedge sys_clk_in) if (wr_in.valid) mem[wr_in.idx] <= wr_in.data;
endmodule
`default_nettype wire

// >>> extend_and_indirect_branch_exec_tb_top.sv
/* bench for ext_branch_exec; assumes checker bound and a 40 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module extend_and_indirect_branch_exec_tb_top;
  logic sys_clk_in = 1'b0, rstn_in = 1'b0, insn_valid_in = 1'b0;
  ext_branch_pkg::fetch_word_t fetch_in = '0;
  logic insn_ready_out, slot_exec_out, except_hold_out;
  logic illegal_slot_out, flag_write_out;
  logic [3:0] src_idx_out;
  logic [31:0] src_data_in, v, a, rng = 32'h00000021;
  logic [15:0] w;
  ext_branch_pkg::reg_write_t gpr_write_out, pr_write_out;
  ext_branch_pkg::pc_load_t pc_load_out;
  int num_errors = 0, total_checks = 0, n;
  // core clock
  always #12.5 sys_clk_in = ~sys_clk_in;
  ext_branch_exec dut (.sys_clk_in, .rstn_in, .insn_valid_in, .fetch_in,
    .insn_ready_out, .src_idx_out, .src_data_in, .gpr_write_out,
    .pr_write_out, .pc_load_out, .slot_exec_out, .except_hold_out,
    .illegal_slot_out, .flag_write_out);
  ext_branch_regs regs (.sys_clk_in, .rd_idx_in(src_idx_out),
    .rd_data_out(src_data_in), .wr_in(gpr_write_out));
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // n counts refused edges; a hang ends the run
  task automatic send(input logic [15:0] iw, input logic [31:0] ia);
    insn_valid_in <= 1'b1;
    fetch_in <= '{iw, ia};
    n = 0;
    do @(posedge sys_clk_in); while (!insn_ready_out && ++n < 20);
    if (insn_ready_out !== 1'b1) begin
      num_errors++;
      report_and_stop();
    end
    #1;
  endtask
  // jump, call, then a branch placed in the slot
  initial begin
    repeat (10) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      w = (k == 1) ? 16'h450B : 16'h432B;
      v = xs();
      a = xs() & 32'hFFFFFFFE;
      regs.mem[w[11:8]] = v;
      send(w, a);
      chk({insn_ready_out, except_hold_out, pr_write_out.valid},
        {2'b01, k == 1});
      if (k == 1) chk(pr_write_out.data, a + 32'h00000004);
      regs.mem[w[11:8]] = ~v;
      send((k == 2) ? 16'h462B : 16'h0009, a + 32'h00000002);
      chk(n, 1);
      chk({illegal_slot_out, slot_exec_out, pc_load_out.valid},
        (k == 2) ? 3'b100 : 3'b011);
      if (k != 2) chk(pc_load_out.target, v);
      $display("branch test %0d done", k);
    end
    // back-to-back extensions, every form in turn
    for (int i = 0; i < 24; i++) begin
      w = {4'h6, 4'(2 * i + 1), 4'(2 * i), 2'b11, 2'(i)};
      v = xs();
      regs.mem[w[7:4]] = v;
      send(w, 32'h00000000);
      if (i > 0) chk(n, 0);
      v = w[0] ? {{16{w[1] & v[15]}}, v[15:0]} : {{24{w[1] & v[7]}}, v[7:0]};
      chk(gpr_write_out, {1'b1, w[11:8], v});
    end
    $display("extend test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
